// ===== verilog/ssq_pkg.sv
// Purpose: Shared constants for the startup wake sequencer.
// Assumes: 20 MHz hclk, 32-bit AHB-Lite register access.
// Notes: Step times are held in milliseconds and counted in 1 ms ticks.
`default_nettype none
package ssq_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
    // Step times from the wake event, and the evaluation period, in ms.
    localparam logic [15:0] T_REG_MS = 16'd20;
    localparam logic [15:0] T_INIT_START_MS = 16'd22;
    localparam logic [15:0] T_INIT_DONE_SLOW_MS = 16'd69;
    localparam logic [15:0] T_INIT_DONE_FAST_MS = 16'd47;
    localparam logic [15:0] T_FULL_SLOW_MS = 16'd164;
    localparam logic [15:0] T_FULL_FAST_MS = 16'd97;
    localparam logic [15:0] T_SW_SLOW_MS = 16'd282;
    localparam logic [15:0] T_SW_FAST_MS = 16'd283;
    localparam logic [7:0] T_EVAL_PERIOD_MS = 8'd250;
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ALARM_SEL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_ELAPSED = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN = 8'h18;
    // Control register fields.
    localparam int CTRL_FAST = 0;
    localparam int CTRL_AUTO_SW = 1;
    localparam int CTRL_AUX_AUTO = 2;
    localparam int CTRL_SHUTDOWN = 3;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    // Flag and status fields.
    localparam int FLG_INIT_START = 0;
    localparam int FLG_INIT_DONE = 1;
    localparam int FLG_VSCAN = 2;
    localparam int FLG_FULL = 3;
    localparam int ST_AUX = 4;
    localparam int ST_SW = 5;
    localparam int ST_NORMAL = 6;
    localparam int ST_AWAKE = 7;
    localparam logic [3:0] ALARM_SEL_RESET = 4'h0;
    // Interrupt event fields.
    localparam int EV_WAKE = 0;
    localparam int EV_INIT_START = 1;
    localparam int EV_INIT_DONE = 2;
    localparam int EV_FULL = 3;
    localparam int EV_SW_ON = 4;
    localparam int EV_W = 5;
    typedef enum logic [1:0] {SEQ_OFF, SEQ_START, SEQ_NORMAL} ssq_state_t;
endpackage : ssq_pkg
`default_nettype wire

// ===== verilog/ssq_ms_tick.sv
// Purpose: One-cycle pulse every millisecond of the internal time base.
// Assumes: Restart holds the divider at zero.
// Notes: The period is a parameter so simulations may shorten it.
`timescale 1ns/100ps
`default_nettype none
module ssq_ms_tick #(
    parameter int unsigned CYC_PER_MS = ssq_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic restart,
    output logic tick
);
    import ssq_pkg::*;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic tick_d;
    logic tick_q;

    always_comb
    begin
        cnt_d = cnt_q + 32'd1;
        tick_d = 1'b0;
        if (restart)
        begin
            cnt_d = 32'h0;
        end
        else if (cnt_q >= CYC_PER_MS - 1)
        begin
            cnt_d = 32'h0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule : ssq_ms_tick
`default_nettype wire

// ===== verilog/ssq_irq.sv
// Purpose: Sticky event status, enable mask and one level interrupt.
// Assumes: Clear strobes last one cycle.
// Notes: A new event in the clearing cycle stays set.
`timescale 1ns/100ps
`default_nettype none
module ssq_irq (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Events and software access
    input wire logic [ssq_pkg::EV_W-1:0] events,
    input wire logic clr_we,
    input wire logic en_we,
    input wire logic [ssq_pkg::EV_W-1:0] wdata,
    // State
    output logic [ssq_pkg::EV_W-1:0] status,
    output logic [ssq_pkg::EV_W-1:0] enable,
    output logic irq
);
    import ssq_pkg::*;
    logic [EV_W-1:0] stat_q;
    logic [EV_W-1:0] stat_d;
    logic [EV_W-1:0] en_q;
    logic [EV_W-1:0] en_d;

    always_comb
    begin
        stat_d = stat_q;
        en_d = en_q;
        if (clr_we)
        begin
            stat_d = stat_d & ~wdata;
        end
        stat_d = stat_d | events;
        if (en_we)
        begin
            en_d = wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stat_q <= '0;
            en_q <= '0;
        end
        else
        begin
            stat_q <= stat_d;
            en_q <= en_d;
        end
    end

    assign status = stat_q;
    assign enable = en_q;
    assign irq = |(stat_q & en_q);
endmodule : ssq_irq
`default_nettype wire

// ===== verilog/ssq_top.sv
// Purpose: Wake-to-normal startup sequencer with AHB-Lite registers.
// Assumes: Wake pins are synchronous to hclk; single word transfers.
// Notes: Step times are nominal and counted in 1 ms ticks.
// Functional notes
// R1 - Thermistor-two low or load-detect high leaves shutdown; wake is time zero.
// R2 - Startup walks ordered steps, then enters normal mode.
// R3 - With auto enable, aux regulator one turns on 20 ms after wake.
// R4 - Init-started flag sets at 22 ms; alarm pin shows it when selected.
// R5 - Init-complete and voltage-scan flags set together at 69 or 47 ms.
// R6 - Full-scan flag sets at 164 ms, or 97 ms with fast conversion.
// R7 - In normal mode, switch-on is evaluated only once per 250 ms.
// R8 - First evaluation turns switches on at 282 or 283 ms.
// R9 - All step times count from wake on the internal time base.
`timescale 1ns/100ps
`default_nettype none
module ssq_top #(
    parameter int unsigned CYC_PER_MS = ssq_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Wake pins
    input wire logic thermistor_two_wake_pin,
    input wire logic load_detect_pin,
    // Device outputs
    output logic aux_regulator_one,
    output logic switches_on,
    output logic alarm_pin,
    output logic irq
);
    import ssq_pkg::*;

    ssq_state_t st_q;
    ssq_state_t st_d;
    logic [2:0] ctrl_q;
    logic [2:0] ctrl_d;
    logic [3:0] asel_q;
    logic [3:0] asel_d;
    logic [3:0] flg_q;
    logic [3:0] flg_d;
    logic [15:0] ms_q;
    logic [15:0] ms_d;
    logic [7:0] per_q;
    logic [7:0] per_d;
    logic first_q;
    logic first_d;
    logic fast_q;
    logic fast_d;
    logic aux_q;
    logic aux_d;
    logic sw_q;
    logic sw_d;
    logic alarm_q;
    logic alarm_d;
    logic wr_q;
    logic wr_d;
    logic [7:0] wa_q;
    logic [7:0] wa_d;
    logic [31:0] rd_q;
    logic [31:0] rd_d;
    logic tick;
    logic wake;
    logic eval;
    logic shut;
    logic [15:0] ms_nx;
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_en;
    logic addr_ok;
    logic ctrl_we;
    logic asel_we;
    logic clr_we;
    logic en_we;
    logic addr_low;

    // Picks the slow or fast figure for a step time.
    function automatic logic [15:0] pick(input logic f, input logic [15:0] slow,
                                         input logic [15:0] quick);
        pick = f ? quick : slow;
    endfunction : pick

    // Word offset of a bus address; the two byte-lane bits never pick a register.
    function automatic logic [7:0] word_ofs(input logic [31:0] a);
        word_ofs = {a[7:2], 2'b00};
    endfunction : word_ofs

    assign addr_ok = hsel && htrans[1] && hready;
    // Only the lowest 256 bytes hold registers; higher addresses read zero and drop writes.
    assign addr_low = (haddr[31:8] == 24'h0);
    assign ctrl_we = wr_q && (wa_q == OFS_CTRL);
    assign asel_we = wr_q && (wa_q == OFS_ALARM_SEL);
    assign clr_we = wr_q && (wa_q == OFS_IRQ_CLR);
    assign en_we = wr_q && (wa_q == OFS_IRQ_EN);
    assign shut = ctrl_we && hwdata[CTRL_SHUTDOWN];

    assign wake = (st_q == SEQ_OFF) && (!thermistor_two_wake_pin || load_detect_pin); // see R1
    assign ms_nx = (ms_q == 16'hffff) ? ms_q : ms_q + 16'd1;
    // Only the 250 ms slot decides, so earlier scan data waits for it.
    assign eval = tick && (st_q == SEQ_NORMAL)
                  && (first_q ? (per_q == T_EVAL_PERIOD_MS - 8'd1)
                              : (ms_nx == pick(fast_q, T_SW_SLOW_MS, T_SW_FAST_MS))); // see R7

    ssq_ms_tick #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .restart(st_q == SEQ_OFF),
        .tick(tick)
    );

    // Bus side.
    always_comb
    begin
        wr_d = addr_ok && hwrite && addr_low;
        wa_d = addr_ok ? word_ofs(haddr) : wa_q;
        ctrl_d = ctrl_we ? hwdata[2:0] : ctrl_q;
        asel_d = asel_we ? hwdata[3:0] : asel_q;
        rd_d = 32'h0;
        if (addr_ok && !hwrite && addr_low)
        begin
            case (word_ofs(haddr))
                OFS_CTRL: rd_d = {29'h0, ctrl_q};
                OFS_ALARM_SEL: rd_d = {28'h0, asel_q};
                OFS_STATUS: rd_d = {24'h0, st_q != SEQ_OFF, st_q == SEQ_NORMAL, sw_q, aux_q, flg_q};
                OFS_ELAPSED: rd_d = {16'h0, ms_q};
                OFS_IRQ_STAT: rd_d = {{(32-EV_W){1'b0}}, irq_stat};
                OFS_IRQ_EN: rd_d = {{(32-EV_W){1'b0}}, irq_en};
                default: rd_d = 32'h0;
            endcase
        end
    end

    // Sequencer.
    always_comb
    begin
        st_d = st_q;
        ms_d = ms_q;
        per_d = per_q;
        first_d = first_q;
        fast_d = fast_q;
        aux_d = aux_q;
        flg_d = flg_q;
        sw_d = sw_q;
        events = '0;
        case (st_q)
            SEQ_OFF:
            begin
                if (wake)
                begin
                    st_d = SEQ_START; // see R1
                    ms_d = 16'h0; // see R9
                    per_d = 8'h0;
                    first_d = 1'b0;
                    fast_d = ctrl_q[CTRL_FAST];
                    events[EV_WAKE] = 1'b1;
                end
            end
            SEQ_START:
            begin
                if (tick)
                begin
                    ms_d = ms_nx; // see R9
                    if (ms_nx == T_REG_MS && ctrl_q[CTRL_AUX_AUTO])
                    begin
                        aux_d = 1'b1; // see R3
                    end
                    if (ms_nx == T_INIT_START_MS)
                    begin
                        flg_d[FLG_INIT_START] = 1'b1; // see R4
                        events[EV_INIT_START] = 1'b1;
                    end
                    if (ms_nx == pick(fast_q, T_INIT_DONE_SLOW_MS, T_INIT_DONE_FAST_MS))
                    begin
                        flg_d[FLG_INIT_DONE] = 1'b1; // see R5
                        flg_d[FLG_VSCAN] = 1'b1; // see R5
                        events[EV_INIT_DONE] = 1'b1;
                    end
                    if (ms_nx == pick(fast_q, T_FULL_SLOW_MS, T_FULL_FAST_MS))
                    begin
                        flg_d[FLG_FULL] = 1'b1; // see R6
                        events[EV_FULL] = 1'b1;
                        st_d = SEQ_NORMAL; // see R2
                    end
                end
            end
            SEQ_NORMAL:
            begin
                if (tick)
                begin
                    ms_d = ms_nx;
                    per_d = (!first_q || eval) ? 8'h0 : per_q + 8'd1; // see R7
                end
                if (eval)
                begin
                    first_d = 1'b1;
                    if (ctrl_q[CTRL_AUTO_SW] && !sw_q)
                    begin
                        sw_d = 1'b1; // see R8
                        events[EV_SW_ON] = 1'b1;
                    end
                end
                if (!ctrl_q[CTRL_AUTO_SW])
                begin
                    sw_d = 1'b0;
                end
            end
            default:
            begin
                st_d = SEQ_OFF;
            end
        endcase
        if (shut)
        begin
            // Shutdown drops the aux, switch and alarm outputs and the flags so the next wake starts clean; interrupt status is kept.
            st_d = SEQ_OFF;
            aux_d = 1'b0;
            sw_d = 1'b0;
            flg_d = 4'h0;
        end
        alarm_d = |(flg_d & asel_q); // see R4
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q <= CTRL_RESET;
            asel_q <= ALARM_SEL_RESET;
            wr_q <= 1'b0;
            wa_q <= 8'h0;
            rd_q <= 32'h0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            asel_q <= asel_d;
            wr_q <= wr_d;
            wa_q <= wa_d;
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q <= SEQ_OFF;
            ms_q <= 16'h0;
            per_q <= 8'h0;
            first_q <= 1'b0;
            fast_q <= 1'b0;
            aux_q <= 1'b0;
            flg_q <= 4'h0;
            sw_q <= 1'b0;
            alarm_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            ms_q <= ms_d;
            per_q <= per_d;
            first_q <= first_d;
            fast_q <= fast_d;
            aux_q <= aux_d;
            flg_q <= flg_d;
            sw_q <= sw_d;
            alarm_q <= alarm_d;
        end
    end

    ssq_irq u_irq (
        .hclk(hclk),
        .hresetn(hresetn),
        .events(events),
        .clr_we(clr_we),
        .en_we(en_we),
        .wdata(hwdata[EV_W-1:0]),
        .status(irq_stat),
        .enable(irq_en),
        .irq(irq)
    );

    // Zero wait states; every access answers OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rd_q;
    assign aux_regulator_one = aux_q;
    assign switches_on = sw_q;
    assign alarm_pin = alarm_q;
endmodule : ssq_top
`default_nettype wire

// ===== verification/ssq_top_checker.sv
// Purpose: Port-level timing checks for the startup wake sequencer.
// Assumes: Wake pins sampled on hclk; shutdown only by reset or control write.
// Notes: Step windows allow the one or two cycle tick lag.
`timescale 1ns/100ps
`default_nettype none
module ssq_top_checker #(
    parameter int unsigned CYC_PER_MS = 10
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Pins
    input wire logic thermistor_two_wake_pin,
    input wire logic load_detect_pin,
    input wire logic aux_regulator_one,
    input wire logic switches_on,
    input wire logic alarm_pin
);
    localparam int A0 = 20 * CYC_PER_MS;
    localparam int B0 = 22 * CYC_PER_MS;
    localparam int S0 = 282 * CYC_PER_MS;
    localparam int P0 = 250 * CYC_PER_MS;
    logic awake_q, awake_d, wr_q, wr_d;
    int cnt_q, cnt_d;
    // Tracks awake time itself, so no design state is trusted.
    always_comb
    begin
        wr_d = hsel && htrans[1] && hready && hwrite && haddr == 32'h0;
        awake_d = awake_q;
        cnt_d = cnt_q + 1;
        if (wr_q && hwdata[3])
            awake_d = 1'b0;
        else if (!awake_q && (!thermistor_two_wake_pin || load_detect_pin))
        begin
            awake_d = 1'b1;
            cnt_d = 0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            awake_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 0;
        end
        else
        begin
            awake_q <= awake_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence addr_phase_s;
        hsel && htrans[1] && hready;
    endsequence
    no_wait_a: assert property (hreadyout) else $error("wait state seen");
    resp_okay_a: assert property (!hresp) else $error("error response seen");
    wr_zero_a: assert property (addr_phase_s ##0 hwrite |=> hrdata == 32'h0)
        else $error("read data after write not zero");
    unmapped_zero_a: assert property (addr_phase_s ##0 (!hwrite && haddr[31:5] != 0)
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    aux_time_a: assert property ($rose(aux_regulator_one) |-> cnt_q >= A0 && cnt_q <= A0 + 3)
        else $error("aux regulator off time");
    alarm_early_a: assert property ($rose(alarm_pin) |-> cnt_q >= B0)
        else $error("alarm before init start");
    sw_first_a: assert property ($rose(switches_on) |-> cnt_q >= S0)
        else $error("switches before first evaluation");
    sw_period_a: assert property ($rose(switches_on) |-> (cnt_q - S0) % P0 <= CYC_PER_MS + 3)
        else $error("switches off evaluation grid");
    asleep_quiet_a: assert property (!awake_q |=> !aux_regulator_one && !switches_on
        && !alarm_pin) else $error("output active in shutdown");
endmodule : ssq_top_checker
bind ssq_top ssq_top_checker #(.CYC_PER_MS(CYC_PER_MS)) chk_u (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .thermistor_two_wake_pin,
    .load_detect_pin, .aux_regulator_one, .switches_on, .alarm_pin);
`default_nettype wire

// ===== verification/ssq_host_model.sv
// Purpose: Host that watches the alarm pin and times its latest rise since restart.
// Assumes: Restart pulses on the cycle the wake pin is driven.
// Notes: Reports -1 while no rise was seen.
`timescale 1ns/100ps
`default_nettype none
module ssq_host_model (
    // Clock
    input wire logic hclk,
    // Alarm watch
    input wire logic restart,
    input wire logic alarm_pin,
    output int rise_at
);
    int cnt = 0;
    logic prev = 1'b0;
    always @(posedge hclk)
    begin
        prev <= alarm_pin;
        cnt <= restart ? 0 : cnt + 1;
        if (restart || alarm_pin && !prev)
            rise_at <= restart ? -1 : cnt;
    end
endmodule : ssq_host_model
`default_nettype wire

// ===== verification/tb_ssq_top.sv
// Purpose: Walks wake, startup steps, re-evaluation and shutdown.
// Assumes: One tick per 10 clocks to keep the run short.
// Notes: Step times are checked with a small cycle window.
`timescale 1ns/100ps
`default_nettype none
module tb_ssq_top;
    import ssq_pkg::*;
    localparam int C = 10;
    logic hclk = 1'b0;
    logic hresetn, hwrite, thermistor_two_wake_pin, load_detect_pin, wk;
    logic hreadyout, hresp, aux_regulator_one, switches_on, alarm_pin, irq, aux_p, sw_p, irq_p;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int mismatches = 0, checked = 0, cnt = 0, t_aux, t_sw, t_irq, t_alarm;
    logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h40};
    always #25 hclk = ~hclk;
    ssq_top #(.CYC_PER_MS(C)) dut_u (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .thermistor_two_wake_pin, .load_detect_pin, .aux_regulator_one, .switches_on,
        .alarm_pin, .irq);
    ssq_host_model host_u (.hclk, .restart(wk), .alarm_pin, .rise_at(t_alarm));
    always @(posedge hclk)
    begin
        {aux_p, sw_p, irq_p} <= {aux_regulator_one, switches_on, irq};
        cnt <= wk ? 0 : cnt + 1;
        if (wk || aux_regulator_one && !aux_p)
            t_aux <= wk ? -1 : cnt;
        if (wk || switches_on && !sw_p)
            t_sw <= wk ? -1 : cnt;
        if (wk || irq && !irq_p)
            t_irq <= wk ? -1 : cnt;
    end
    task finish_test;
        if (mismatches == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task chk_t(input int got, input int ms);
        chk(32'(got >= ms * C - 2 && got <= ms * C + 4), 32'h1);
    endtask : chk_t
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc
    task ms(input int n);
        repeat (n * C) @(posedge hclk);
    endtask : ms
    // The wake pin is pulsed for one cycle only, so shutdown later stays put.
    task wake(input logic by_ld);
        @(posedge hclk);
        load_detect_pin <= by_ld;
        thermistor_two_wake_pin <= by_ld;
        wk <= 1'b1;
        @(posedge hclk);
        load_detect_pin <= 1'b0;
        thermistor_two_wake_pin <= 1'b1;
        wk <= 1'b0;
    endtask : wake
    initial
    begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        finish_test;
    end
    initial
    begin
        {hresetn, hwrite, htrans, haddr, hwdata, load_detect_pin, wk} = '0;
        thermistor_two_wake_pin = 1'b1;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (offs[i])
            rdc(offs[i], 32'h0);
        ahb(1'b1, OFS_CTRL, 32'h6);
        ahb(1'b1, OFS_ALARM_SEL, 32'h2);
        ahb(1'b1, OFS_IRQ_EN, 32'h8);
        wake(1'b1);
        ms(100);
        rdc(OFS_STATUS, 32'h97);
        ms(190);
        chk_t(t_aux, 20);
        chk_t(t_alarm, 69);
        chk_t(t_irq, 164);
        chk_t(t_sw, 282);
        rdc(OFS_STATUS, 32'hff);
        rdc(OFS_IRQ_STAT, 32'h1f);
        ahb(1'b1, OFS_IRQ_CLR, 32'h8);
        rdc(OFS_IRQ_STAT, 32'h17);
        chk({31'h0, irq}, 32'h0);
        ahb(1'b1, OFS_CTRL, 32'h4);
        ahb(1'b1, OFS_CTRL, 32'h6);
        chk({31'h0, switches_on}, 32'h0);
        ms(5);
        chk({31'h0, switches_on}, 32'h0);
        ms(240);
        chk_t(t_sw, 532);
        ahb(1'b1, OFS_CTRL, 32'h8);
        ms(1);
        chk({29'h0, aux_regulator_one, switches_on, alarm_pin}, 32'h0);
        rdc(OFS_STATUS, 32'h0);
        ahb(1'b1, OFS_IRQ_CLR, 32'h1f);
        ahb(1'b1, OFS_CTRL, 32'h7);
        ahb(1'b1, OFS_ALARM_SEL, 32'h1);
        wake(1'b0);
        ms(60);
        rdc(OFS_STATUS, 32'h97);
        ms(230);
        chk_t(t_aux, 20);
        chk_t(t_alarm, 22);
        chk_t(t_irq, 97);
        chk_t(t_sw, 283);
        ahb(1'b1, OFS_CTRL, 32'h8);
        wake(1'b1);
        ms(290);
        chk({30'h0, aux_regulator_one, switches_on}, 32'h0);
        rdc(OFS_STATUS, 32'hcf);
        rdc(OFS_ELAPSED, 32'h122);
        finish_test;
    end
endmodule : tb_ssq_top
`default_nettype wire
